// ---- include/atc_pkg.sv ----
/*
  Package for the accumulator-to-control-register transfer decoder:
  opcodes, field positions, widths and reset values.
  Assumes a 10-bit instruction word and 4-bit accumulator nibbles.
*/
package atc_pkg;

  localparam int NIB = 4;
  localparam int OPW = 10;
  localparam int RAM_AW = 9;

  localparam logic [OPW-1:0] OP_IRQ1    = 10'h217;
  localparam logic [OPW-1:0] OP_IRQ2    = 10'h218;
  localparam logic [OPW-1:0] OP_IRQ3    = 10'h21A;
  localparam logic [OPW-1:0] OP_SER     = 10'h202;
  localparam logic [OPW-1:0] OP_WAKE0   = 10'h21B;
  localparam logic [OPW-1:0] OP_WAKE1   = 10'h214;
  localparam logic [OPW-1:0] OP_WAKE2   = 10'h215;
  localparam logic [OPW-1:0] OP_LCD1    = 10'h20A;
  localparam logic [OPW-1:0] OP_LCD2    = 10'h20B;
  localparam logic [OPW-1:0] OP_AUXT    = 10'h20D;
  localparam logic [OPW-1:0] OP_MODE    = 10'h216;
  localparam logic [OPW-1:0] OP_PGATE   = 10'h2AA;
  localparam logic [OPW-1:0] OP_PSC     = 10'h235;
  localparam logic [OPW-1:0] OP_PU0     = 10'h22D;
  localparam logic [OPW-1:0] OP_PU1     = 10'h22E;
  localparam logic [OPW-1:0] OP_ADC1    = 10'h204;
  localparam logic [OPW-1:0] OP_ADC2    = 10'h205;
  localparam logic [OPW-1:0] OP_ADC3    = 10'h206;
  localparam logic [OPW-1:0] OP_T1R     = 10'h23F;
  localparam logic [OPW-1:0] OP_T3R     = 10'h23B;
  localparam logic [OPW-1:0] OP_SHIFT   = 10'h238;
  localparam logic [OPW-1:0] OP_IEN1    = 10'h03F;
  localparam logic [OPW-1:0] OP_IEN2    = 10'h03E;
  localparam logic [5:0]     OP_TMA_HI  = 6'h2B;

  localparam int IMM_LSB = 0;

  localparam logic [NIB-1:0]   RST_NIB  = 4'h0;
  localparam logic [2*NIB-1:0] RST_BYTE = 8'h00;
  localparam logic             RST_BIT  = 1'b0;

  // One strobe per destination
  localparam int N_TGT = 24;
  typedef enum int unsigned {
    T_IRQ1, T_IRQ2, T_IRQ3, T_SER, T_WAKE0, T_WAKE1, T_WAKE2, T_LCD1,
    T_LCD2, T_AUXT, T_MODE, T_PGATE, T_PSC, T_PU0, T_PU1, T_ADC1,
    T_ADC2, T_ADC3, T_T1R, T_T3R, T_SHIFT, T_IEN1, T_IEN2, T_TMA
  } atc_tgt_type;

endpackage : atc_pkg

// ---- rtl/atc_decode.sv ----
/*
  Combinational opcode decoder: one-hot target strobe from a 10-bit word.
  Assumes the caller qualifies the result with an instruction-valid pulse.
*/
`timescale 1ns/1ns
module atc_decode
  import atc_pkg::*;
(
  input  wire logic [OPW-1:0]   opcode,
  output logic      [N_TGT-1:0] tgt
);

  always_comb
  begin
    tgt = '0;
    unique case (opcode)
      OP_IRQ1:  tgt[T_IRQ1]  = 1'b1;
      OP_IRQ2:  tgt[T_IRQ2]  = 1'b1;
      OP_IRQ3:  tgt[T_IRQ3]  = 1'b1;
      OP_SER:   tgt[T_SER]   = 1'b1;
      OP_WAKE0: tgt[T_WAKE0] = 1'b1;
      OP_WAKE1: tgt[T_WAKE1] = 1'b1;
      OP_WAKE2: tgt[T_WAKE2] = 1'b1;
      OP_LCD1:  tgt[T_LCD1]  = 1'b1;
      OP_LCD2:  tgt[T_LCD2]  = 1'b1;
      OP_AUXT:  tgt[T_AUXT]  = 1'b1;
      OP_MODE:  tgt[T_MODE]  = 1'b1;
      OP_PGATE: tgt[T_PGATE] = 1'b1;
      OP_PSC:   tgt[T_PSC]   = 1'b1;
      OP_PU0:   tgt[T_PU0]   = 1'b1;
      OP_PU1:   tgt[T_PU1]   = 1'b1;
      OP_ADC1:  tgt[T_ADC1]  = 1'b1;
      OP_ADC2:  tgt[T_ADC2]  = 1'b1;
      OP_ADC3:  tgt[T_ADC3]  = 1'b1;
      OP_T1R:   tgt[T_T1R]   = 1'b1;
      OP_T3R:   tgt[T_T3R]   = 1'b1;
      OP_SHIFT: tgt[T_SHIFT] = 1'b1;
      OP_IEN1:  tgt[T_IEN1]  = 1'b1;
      OP_IEN2:  tgt[T_IEN2]  = 1'b1;
      default:
      begin
        if (opcode[OPW-1:NIB] == OP_TMA_HI)
          tgt[T_TMA] = 1'b1;
      end
    endcase
  end

endmodule : atc_decode

// ---- rtl/atc_xfer.sv ----
/*
  Accumulator-to-control-register transfer block: decodes one instruction
  word per machine cycle and loads the addressed control register.
  Assumes ins_valid is a one-cycle pulse per machine cycle from the core,
  all inputs are on clk_sys, and the RAM accepts one write per cycle.
*/
// Behaviour
// RL1: One word, one cycle, no carry, no skip
// RL2: 0x217 loads irq_ctrl_1 from accumulator
// RL3: 0x218 loads irq_ctrl_2 from accumulator
// RL4: 0x21A loads irq_ctrl_3 bit 0 only
// RL5: 0x202 loads serial_ctrl from accumulator
// RL6: Wake control registers 0,1,2 loaded
// RL7: 0x20A/0x20B load lcd_ctrl_1 and lcd_ctrl_2
// RL8: Aux timer count and reload loaded together
// RL9: RAM store then column pointer XOR immediate
// RL10: 0x216 loads clock_mode_reg from accumulator
// RL11: Prescaler gate bit 0 only written
// RL12: Prescaler and reload get second nibble:accumulator
// RL13: Two instructions load resistor_ctrl_0 and resistor_ctrl_1
// RL14: 0x204..0x206 load adc_ctrl_1..3
// RL15: 0x23F loads timer1_reload from nibble pair
// RL16: 0x23B loads timer3_reload from nibble pair
// RL17: 0x238 loads serial shift register from pair
// RL18: 0x03F/0x03E load irq_enable_1 and irq_enable_2
// RL19: One-cycle strobe to exactly one target
`timescale 1ns/1ns
module atc_xfer
  import atc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                ins_valid,
  input  wire logic [OPW-1:0]      ins_word,
  input  wire logic [NIB-1:0]      acc,
  input  wire logic [NIB-1:0]      reg_b,
  input  wire logic [NIB-1:0]      col_ptr,
  input  wire logic [RAM_AW-1:0]   data_pointer,
  output logic                     done_ff,
  output logic                     carry_we_ff,
  output logic                     skip_ff,
  output logic [N_TGT-1:0]         strobe_ff,
  output logic [NIB-1:0]           irq_ctrl_1_ff,
  output logic [NIB-1:0]           irq_ctrl_2_ff,
  output logic                     irq_ctrl_3_ff,
  output logic [NIB-1:0]           irq_enable_1_ff,
  output logic [NIB-1:0]           irq_enable_2_ff,
  output logic [NIB-1:0]           serial_ctrl_ff,
  output logic [NIB-1:0]           wake_ctrl_0_ff,
  output logic [NIB-1:0]           wake_ctrl_1_ff,
  output logic [NIB-1:0]           wake_ctrl_2_ff,
  output logic [NIB-1:0]           lcd_ctrl_1_ff,
  output logic [NIB-1:0]           lcd_ctrl_2_ff,
  output logic [NIB-1:0]           aux_timer_count_ff,
  output logic [NIB-1:0]           aux_timer_reload_ff,
  output logic [NIB-1:0]           clock_mode_reg_ff,
  output logic                     prescaler_gate_reg_ff,
  output logic [2*NIB-1:0]         prescaler_ff,
  output logic [2*NIB-1:0]         prescaler_reload_ff,
  output logic [NIB-1:0]           resistor_ctrl_0_ff,
  output logic [NIB-1:0]           resistor_ctrl_1_ff,
  output logic [NIB-1:0]           adc_ctrl_1_ff,
  output logic [NIB-1:0]           adc_ctrl_2_ff,
  output logic [NIB-1:0]           adc_ctrl_3_ff,
  output logic [2*NIB-1:0]         timer1_reload_ff,
  output logic [2*NIB-1:0]         timer3_reload_ff,
  output logic [2*NIB-1:0]         serial_shift_ff,
  output logic                     ram_we_ff,
  output logic [RAM_AW-1:0]        ram_addr_ff,
  output logic [NIB-1:0]           ram_wdata_ff,
  output logic                     col_ptr_we_ff,
  output logic [NIB-1:0]           nxt_col_ptr_ff
);

  logic [N_TGT-1:0] dec_tgt;
  logic [N_TGT-1:0] hit;
  logic [2*NIB-1:0] pair;

  atc_decode u_dec
  (
    .opcode (ins_word),
    .tgt    (dec_tgt)
  );

  // Decoder is one-hot, so at most one destination fires per word
  assign hit  = ins_valid ? dec_tgt : '0; // RL19
  assign pair = {reg_b, acc};

  // Every decoded word finishes in the cycle it is presented; unknown words leave done_ff low
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      done_ff   <= RST_BIT;
      strobe_ff <= '0;
    end
    else
    begin
      done_ff   <= |hit; // RL1
      strobe_ff <= hit; // RL19
    end
  end

  // The group never writes carry and never requests a skip; the core
  // still gets explicit zeros so its flag logic needs no special case
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      carry_we_ff <= RST_BIT;
      skip_ff     <= RST_BIT;
    end
    else
    begin
      carry_we_ff <= RST_BIT; // RL1
      skip_ff     <= RST_BIT; // RL1
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_ctrl_1_ff <= RST_NIB;
    else if (hit[T_IRQ1])
      irq_ctrl_1_ff <= acc; // RL2
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_ctrl_2_ff <= RST_NIB;
    else if (hit[T_IRQ2])
      irq_ctrl_2_ff <= acc; // RL3
  end

  // Only bit 0 of this register lives here; the upper accumulator bits
  // are dropped on purpose
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_ctrl_3_ff <= RST_BIT;
    else if (hit[T_IRQ3])
      irq_ctrl_3_ff <= acc[0]; // RL4
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_enable_1_ff <= RST_NIB;
    else if (hit[T_IEN1])
      irq_enable_1_ff <= acc; // RL18
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_enable_2_ff <= RST_NIB;
    else if (hit[T_IEN2])
      irq_enable_2_ff <= acc; // RL18
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      serial_ctrl_ff <= RST_NIB;
    else if (hit[T_SER])
      serial_ctrl_ff <= acc; // RL5
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      serial_shift_ff <= RST_BYTE;
    else if (hit[T_SHIFT])
      serial_shift_ff <= pair; // RL17
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_ctrl_0_ff <= RST_NIB;
    else if (hit[T_WAKE0])
      wake_ctrl_0_ff <= acc; // RL6
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_ctrl_1_ff <= RST_NIB;
    else if (hit[T_WAKE1])
      wake_ctrl_1_ff <= acc; // RL6
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_ctrl_2_ff <= RST_NIB;
    else if (hit[T_WAKE2])
      wake_ctrl_2_ff <= acc; // RL6
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      resistor_ctrl_0_ff <= RST_NIB;
    else if (hit[T_PU0])
      resistor_ctrl_0_ff <= acc; // RL13
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      resistor_ctrl_1_ff <= RST_NIB;
    else if (hit[T_PU1])
      resistor_ctrl_1_ff <= acc; // RL13
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lcd_ctrl_1_ff <= RST_NIB;
    else if (hit[T_LCD1])
      lcd_ctrl_1_ff <= acc; // RL7
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lcd_ctrl_2_ff <= RST_NIB;
    else if (hit[T_LCD2])
      lcd_ctrl_2_ff <= acc; // RL7
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      clock_mode_reg_ff <= RST_NIB;
    else if (hit[T_MODE])
      clock_mode_reg_ff <= acc; // RL10
  end

  // Counter images are held here only as load values; the timers that
  // count them down take them from these outputs on the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aux_timer_count_ff  <= RST_NIB;
      aux_timer_reload_ff <= RST_NIB;
    end
    else if (hit[T_AUXT])
    begin
      aux_timer_count_ff  <= acc; // RL8
      aux_timer_reload_ff <= acc; // RL8
    end
  end

  // Only the gate bit is held here, so no other bit of that register
  // can be disturbed by this instruction
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prescaler_gate_reg_ff <= RST_BIT;
    else if (hit[T_PGATE])
      prescaler_gate_reg_ff <= acc[0]; // RL11
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prescaler_ff        <= RST_BYTE;
      prescaler_reload_ff <= RST_BYTE;
    end
    else if (hit[T_PSC])
    begin
      prescaler_ff        <= pair; // RL12
      prescaler_reload_ff <= pair; // RL12
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      timer1_reload_ff <= RST_BYTE;
    else if (hit[T_T1R])
      timer1_reload_ff <= pair; // RL15
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      timer3_reload_ff <= RST_BYTE;
    else if (hit[T_T3R])
      timer3_reload_ff <= pair; // RL16
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      adc_ctrl_1_ff <= RST_NIB;
    else if (hit[T_ADC1])
      adc_ctrl_1_ff <= acc; // RL14
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      adc_ctrl_2_ff <= RST_NIB;
    else if (hit[T_ADC2])
      adc_ctrl_2_ff <= acc; // RL14
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      adc_ctrl_3_ff <= RST_NIB;
    else if (hit[T_ADC3])
      adc_ctrl_3_ff <= acc; // RL14
  end

  // Store uses the pointer as presented, so the XOR only affects the
  // next access; both leave together in one cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ram_we_ff    <= RST_BIT;
      ram_addr_ff  <= '0;
      ram_wdata_ff <= RST_NIB;
    end
    else
    begin
      ram_we_ff <= hit[T_TMA]; // RL9
      if (hit[T_TMA])
      begin
        ram_addr_ff  <= data_pointer; // RL9
        ram_wdata_ff <= acc; // RL9
      end
    end
  end

  // The pointer itself lives in the core; only its new value and a
  // write pulse leave here
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      col_ptr_we_ff  <= RST_BIT;
      nxt_col_ptr_ff <= RST_NIB;
    end
    else
    begin
      col_ptr_we_ff <= hit[T_TMA]; // RL9
      if (hit[T_TMA])
        nxt_col_ptr_ff <= col_ptr ^ ins_word[IMM_LSB +: NIB]; // RL9
    end
  end

endmodule : atc_xfer

// ---- tb/acc_to_ctrl_reg_transfer_test.sv ----
/*
  Self-checking bench for atc_xfer with the RAM and column pointer model.
  Assumes the package, design and model files are compiled first.
*/
`timescale 1ns/1ns
module acc_to_ctrl_reg_transfer_test
  import atc_pkg::*;
;
  logic clk_sys, sys_rst, ins_valid, done_ff, carry_we_ff, skip_ff, ram_we_ff, col_ptr_we_ff;
  logic irq_ctrl_3_ff, prescaler_gate_reg_ff;
  logic [OPW-1:0] ins_word;
  logic [RAM_AW-1:0] data_pointer, ram_addr_ff;
  logic [N_TGT-1:0] strobe_ff;
  logic [NIB-1:0] acc, reg_b, col_ptr, ram_wdata_ff, nxt_col_ptr_ff, irq_ctrl_1_ff;
  logic [NIB-1:0] irq_ctrl_2_ff, irq_enable_1_ff, irq_enable_2_ff, serial_ctrl_ff, wake_ctrl_0_ff;
  logic [NIB-1:0] wake_ctrl_1_ff, wake_ctrl_2_ff, lcd_ctrl_1_ff, lcd_ctrl_2_ff, clock_mode_reg_ff;
  logic [NIB-1:0] aux_timer_count_ff, aux_timer_reload_ff, resistor_ctrl_0_ff, resistor_ctrl_1_ff;
  logic [NIB-1:0] adc_ctrl_1_ff, adc_ctrl_2_ff, adc_ctrl_3_ff;
  logic [2*NIB-1:0] prescaler_ff, prescaler_reload_ff, timer1_reload_ff, timer3_reload_ff;
  logic [2*NIB-1:0] serial_shift_ff;
  logic [7:0] view [23];
  logic [7:0] ev [23];
  int n_fail, cmp_count;
  localparam logic [OPW-1:0] OPS [23] = '{OP_IRQ1, OP_IRQ2, OP_IRQ3, OP_SER, OP_WAKE0, OP_WAKE1,
    OP_WAKE2, OP_LCD1, OP_LCD2, OP_AUXT, OP_MODE, OP_PGATE, OP_PSC, OP_PU0, OP_PU1, OP_ADC1,
    OP_ADC2, OP_ADC3, OP_T1R, OP_T3R, OP_SHIFT, OP_IEN1, OP_IEN2};
  // Target registers in strobe index order, widened to one byte
  assign view = '{8'(irq_ctrl_1_ff), 8'(irq_ctrl_2_ff), 8'(irq_ctrl_3_ff), 8'(serial_ctrl_ff),
    8'(wake_ctrl_0_ff), 8'(wake_ctrl_1_ff), 8'(wake_ctrl_2_ff), 8'(lcd_ctrl_1_ff),
    8'(lcd_ctrl_2_ff), 8'(aux_timer_count_ff), 8'(clock_mode_reg_ff), 8'(prescaler_gate_reg_ff),
    prescaler_ff, 8'(resistor_ctrl_0_ff), 8'(resistor_ctrl_1_ff), 8'(adc_ctrl_1_ff),
    8'(adc_ctrl_2_ff), 8'(adc_ctrl_3_ff), timer1_reload_ff, timer3_reload_ff, serial_shift_ff,
    8'(irq_enable_1_ff), 8'(irq_enable_2_ff)};

  atc_xfer DUT (.*);
  atc_ram_model u_mem (.*);

  always #20 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [N_TGT-1:0] e, input logic [N_TGT-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic run_op(input logic v, input logic [OPW-1:0] op, input logic [NIB-1:0] a,
                        input logic [NIB-1:0] b, input logic [RAM_AW-1:0] dp);
    @(posedge clk_sys);
    ins_valid <= v;
    ins_word <= op;
    acc <= a;
    reg_b <= b;
    data_pointer <= dp;
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
  endtask : run_op

  task automatic chk_regs();
    for (int k = 0; k < 23; k++)
      chk($sformatf("target %0d", k), 24'(ev[k]), 24'(view[k]));
  endtask : chk_regs

  task automatic t_all_targets();
    logic [NIB-1:0] a, b;
    for (int i = 0; i < 23; i++)
    begin
      // Odd and non-zero, so even the single-bit targets show each write
      a = 4'(2 * i + 1);
      b = ~a;
      run_op(1'b1, OPS[i], a, b, 9'h000);
      if (i inside {T_PSC, T_T1R, T_T3R, T_SHIFT})
        ev[i] = {b, a};
      else if (i inside {T_IRQ3, T_PGATE})
        ev[i] = {7'h00, a[0]};
      else
        ev[i] = {4'h0, a};
      chk("strobe", 24'h00_0001 << i, strobe_ff);
      chk("flags", 24'h00_0004, 24'({done_ff, carry_we_ff, skip_ff}));
      chk_regs();
    end
    chk("aux_reload", 24'(ev[T_AUXT]), 24'(aux_timer_reload_ff));
    chk("psc_reload", 24'(ev[T_PSC]), 24'(prescaler_reload_ff));
    $display("t_all_targets done");
  endtask : t_all_targets

  task automatic t_refused();
    run_op(1'b1, 10'h3FF, 4'h9, 4'h9, 9'h000);
    chk("unknown", 24'h00_0000, strobe_ff | 24'({done_ff, ram_we_ff}));
    run_op(1'b0, OP_IRQ1, 4'h9, 4'h9, 9'h000);
    chk("no_valid", 24'h00_0000, strobe_ff | 24'({done_ff, ram_we_ff}));
    chk_regs();
    $display("t_refused done");
  endtask : t_refused

  task automatic t_ram_store();
    logic [NIB-1:0] col;
    col = 4'h0;
    for (int j = 0; j < 16; j++)
    begin
      run_op(1'b1, {OP_TMA_HI, 4'(j)}, 4'(j) ^ 4'hC, 4'h0, 9'(j * 31));
      chk("ram_wr", 24'({1'b1, 9'(j * 31), 4'(j) ^ 4'hC}),
          24'({ram_we_ff, ram_addr_ff, ram_wdata_ff}));
      col = col ^ 4'(j);
      chk("col", 24'({1'b1, col}), 24'({col_ptr_we_ff, nxt_col_ptr_ff}));
      chk("tma_strobe", 24'h80_0000, strobe_ff);
    end
    @(posedge clk_sys);
    #1;
    for (int j = 0; j < 16; j++)
      chk("mem", 24'(4'(j) ^ 4'hC), 24'(u_mem.mem[9'(j * 31)]));
    chk("col_ptr", 24'(col), 24'(col_ptr));
    chk_regs();
    $display("t_ram_store done");
  endtask : t_ram_store

  task automatic t_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    ev = '{default: 8'h00};
    chk_regs();
    chk("rst_strobe", 24'h00_0000, strobe_ff);
    chk("rst_out", 24'h00_0000, 24'({done_ff, col_ptr_we_ff, ram_we_ff, ram_addr_ff,
        ram_wdata_ff, nxt_col_ptr_ff, col_ptr}));
    run_op(1'b1, OP_IEN2, 4'h3, 4'hC, 9'h000);
    ev[T_IEN2] = 8'h03;
    chk_regs();
    $display("t_reset done");
  endtask : t_reset

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    ins_valid = 1'b0;
    ins_word = 10'h000;
    acc = 4'h0;
    reg_b = 4'h0;
    data_pointer = 9'h000;
    n_fail = 0;
    cmp_count = 0;
    ev = '{default: 8'h00};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_all_targets();
    t_refused();
    t_ram_store();
    t_reset();
    complete_run();
  end

  // Hang guard: far beyond the roughly 100 cycles the run needs
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule : acc_to_ctrl_reg_transfer_test

bind atc_xfer atc_chk u_chk (.*);

// ---- tb/atc_ram_model.sv ----
/*
  Far-side model: RAM nibbles and the column pointer register.
  Assumes write pulses last one clk_sys cycle.
*/
`timescale 1ns/1ns
module atc_ram_model
  import atc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              ram_we_ff,
  input  wire logic [RAM_AW-1:0] ram_addr_ff,
  input  wire logic [NIB-1:0]    ram_wdata_ff,
  input  wire logic              col_ptr_we_ff,
  input  wire logic [NIB-1:0]    nxt_col_ptr_ff,
  output logic      [NIB-1:0]    col_ptr
);
  logic [NIB-1:0] mem [2**RAM_AW];
  always @(posedge clk_sys)
  begin
    if (ram_we_ff)
      mem[ram_addr_ff] <= ram_wdata_ff;
    if (sys_rst)
      col_ptr <= 4'h0;
    else if (col_ptr_we_ff)
      col_ptr <= nxt_col_ptr_ff;
  end
endmodule : atc_ram_model

// ---- tb/atc_xfer_sva.sv ----
/*
  Checker for the transfer decoder, bound to atc_xfer and fed by its ports.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ns
module atc_chk
  import atc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              ins_valid,
  input wire logic [OPW-1:0]    ins_word,
  input wire logic [NIB-1:0]    acc,
  input wire logic [NIB-1:0]    reg_b,
  input wire logic [NIB-1:0]    col_ptr,
  input wire logic [RAM_AW-1:0] data_pointer,
  input wire logic              done_ff,
  input wire logic              carry_we_ff,
  input wire logic              skip_ff,
  input wire logic [N_TGT-1:0]  strobe_ff,
  input wire logic [NIB-1:0]    irq_ctrl_1_ff,
  input wire logic              irq_ctrl_3_ff,
  input wire logic [2*NIB-1:0]  timer1_reload_ff,
  input wire logic              ram_we_ff,
  input wire logic [RAM_AW-1:0] ram_addr_ff,
  input wire logic [NIB-1:0]    ram_wdata_ff,
  input wire logic              col_ptr_we_ff,
  input wire logic [NIB-1:0]    nxt_col_ptr_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_tma;
    ins_valid && ins_word[OPW-1:4] == OP_TMA_HI;
  endsequence
  sequence s_ram_wr;
    ram_we_ff && ram_addr_ff == $past(data_pointer) && ram_wdata_ff == $past(acc);
  endsequence

  a_flags_zero: assert property (!carry_we_ff && !skip_ff)
    else $error("carry or skip written");
  a_one_strobe: assert property (done_ff |-> $onehot(strobe_ff))
    else $error("strobe not one-hot");
  a_strobe_cause: assert property (|strobe_ff |-> $past(ins_valid) && done_ff)
    else $error("strobe without instruction");
  a_idle_quiet: assert property (!ins_valid |=> strobe_ff == '0 && !ram_we_ff)
    else $error("activity while idle");
  a_irq1_load: assert property (ins_valid && ins_word == OP_IRQ1
    |=> irq_ctrl_1_ff == $past(acc) && strobe_ff[T_IRQ1]) else $error("irq_ctrl_1 load");
  a_irq3_bit: assert property (ins_valid && ins_word == OP_IRQ3
    |=> irq_ctrl_3_ff == $past(acc[0])) else $error("irq_ctrl_3 bit");
  a_t1r_pair: assert property (ins_valid && ins_word == OP_T1R
    |=> timer1_reload_ff == {$past(reg_b), $past(acc)}) else $error("timer1_reload pair");
  a_tma_store: assert property (s_tma |=> s_ram_wr ##0 col_ptr_we_ff)
    else $error("RAM store missing");
  a_col_xor: assert property (s_tma
    |=> nxt_col_ptr_ff == ($past(col_ptr) ^ $past(ins_word[3:0]))) else $error("column xor");
endmodule : atc_chk
